// >>> hdl/pcilh_local_side.sv
// fifo and local-side handshake logic for the pci interface core
`timescale 1ns/1ps

//==========================================================
// fifo with valid/ready on both sides
module pcilh_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage words
    logic [AW:0]      wr_ptr_reg;    // extra bit tells full from empty
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                       || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage needs no reset, only pointers do
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

//==========================================================
// local-side handshake top
module pcilh_local_side (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        bus32_mode,          // local data bus is 32 bits
    // decode information from the pci side of the core
    input  wire logic        pci_addr_valid,      // address phase decoded this cycle
    input  wire logic [5:0]  pci_bar_match,       // address inside each window
    input  wire logic        pci_exprom_match,
    input  wire logic        pci_cfg_access,      // configuration access to this function
    input  wire logic [7:0]  pci_cfg_offset,
    input  wire logic        pci_special_cycle,
    // target data from the pci side
    input  wire logic        pci_wr_valid,        // target write word offered
    output logic             pci_wr_ready,        // fifo has room
    input  wire logic [31:0] pci_wr_data,
    input  wire logic        pci_rd_req,          // target read wants a local word
    output logic [31:0]      tgt_rd_word,         // word taken from the local bus
    // master side events from the pci side
    output logic             pci_req,             // ask the arbiter for the bus
    input  wire logic        pci_gnt,             // arbiter grant
    input  wire logic        pci_phase_ok,        // pci side can move a data phase
    input  wire logic        pci_latency_expired,
    input  wire logic [31:0] pci_mst_rd_data,     // master read word from the bus
    output logic [31:0]      mst_wr_word,         // master write word for the bus
    // back-end target side
    input  wire logic        tgt_backend_ready_n,
    output logic             tgt_xfer_strobe_n,
    output logic             tgt_access_strobe_n,
    output logic [5:0]       bar_hit,
    output logic             ext_cap_hit,
    // back-end master side
    input  wire logic        mst_request_narrow_n,
    input  wire logic        mst_request_wide_n,
    input  wire logic        mst_cmd_read,        // direction the back-end wants
    input  wire logic        mst_backend_ready_n,
    input  wire logic [11:0] mst_phase_count,
    input  wire logic        mst_cancel_n,
    output logic             mst_granted_n,
    output logic             mst_xfer_strobe_n,
    output logic             mst_read_not_write,
    output logic             mst_expired_n,
    output logic [3:0]       mst_phase_state,
    // shared local data buses
    input  wire logic [31:0] l_ad_in,
    output logic [31:0]      l_data_out
);
    //==========================================================
    // helpers
    // widen the back-end phase count, zero is the largest burst
    function automatic logic [12:0] burst_len(input logic [11:0] n);
        return (n == 12'h000) ? pcilh_pkg::BURST_MAX : {1'b0, n};
    endfunction

    // capability window sits above the built-in header
    function automatic logic cap_window(input logic acc, input logic [7:0] off);
        return acc && (off >= pcilh_pkg::CFG_EXT_LO);
    endfunction

    //==========================================================
    // decode
    logic [5:0] bar_hit_reg;
    logic       ext_cap_hit_reg;
    logic       access_n_reg;
    logic       cap_now;          // capability hit this cycle
    logic       any_hit;          // any address hit that opens the local target; special cycles open it too

    assign cap_now = cap_window(pci_cfg_access, pci_cfg_offset);
    assign any_hit = pci_addr_valid && ((|pci_bar_match) || pci_exprom_match || cap_now);

    // hit outputs follow the decoded address phase by one edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bar_hit_reg     <= 6'h00;
            ext_cap_hit_reg <= 1'b0;
            access_n_reg    <= 1'b1;
        end else begin
            bar_hit_reg     <= pci_addr_valid ? pci_bar_match : 6'h00;
            ext_cap_hit_reg <= pci_addr_valid && cap_now;
            access_n_reg    <= !(any_hit || pci_special_cycle);
        end
    end

    //==========================================================
    // target path: write words queue in the fifo
    logic        fifo_valid;
    logic [31:0] fifo_data;
    logic        tgt_pop;         // fifo word goes out this edge
    logic        tgt_take;        // local input word is wanted
    logic        tgt_strobe_n_reg;
    logic        tgt_rd_phase_reg; // strobe marks a read phase
    logic [31:0] tgt_rd_word_reg;

    // strobes only move data on the 32-bit bus, a wide bus stalls here
    assign tgt_pop  = fifo_valid && !tgt_backend_ready_n && bus32_mode && tgt_strobe_n_reg;
    assign tgt_take = pci_rd_req && !fifo_valid && !tgt_backend_ready_n && bus32_mode
                      && tgt_strobe_n_reg;

    pcilh_fifo #(
        .WIDTH (pcilh_pkg::DATA_W),
        .DEPTH (pcilh_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (pci_wr_valid),
        .in_ready  (pci_wr_ready),
        .in_data   (pci_wr_data),
        .out_valid (fifo_valid),
        .out_ready (tgt_pop),
        .out_data  (fifo_data)
    );

    // one strobe cycle per word; a gap cycle keeps each strobe distinct
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tgt_strobe_n_reg <= 1'b1;
            tgt_rd_phase_reg <= 1'b0;
        end else begin
            tgt_strobe_n_reg <= !(tgt_pop || tgt_take);
            tgt_rd_phase_reg <= tgt_take;
        end
    end

    // the back-end holds its word through the strobe cycle, so take it then
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tgt_rd_word_reg <= pcilh_pkg::WORD_RST;
        end else if (!tgt_strobe_n_reg && tgt_rd_phase_reg) begin
            tgt_rd_word_reg <= l_ad_in;
        end
    end

    //==========================================================
    // master sequencer
    pcilh_pkg::pcilh_mstate_t mstate_reg;
    pcilh_pkg::pcilh_mreq_t   mreq_reg;
    logic       req_any;          // either request input low
    logic       mst_move;         // a data phase moves this edge
    logic       mst_stop;         // transaction ends this edge
    logic       timed_out;
    logic       pci_req_reg;
    logic       granted_n_reg;
    logic       mst_strobe_n_reg;
    logic       expired_n_reg;
    logic [3:0] phase_reg;
    logic [31:0] mst_wr_word_reg;
    logic [31:0] l_data_out_reg;

    assign req_any   = !mst_request_narrow_n || !mst_request_wide_n;
    assign timed_out = pci_latency_expired && !pci_gnt;
    assign mst_move  = (mstate_reg == pcilh_pkg::PCILH_M_XFER) && !mst_backend_ready_n
                       && pci_phase_ok && bus32_mode;
    assign mst_stop  = (mstate_reg == pcilh_pkg::PCILH_M_XFER)
                       && ((mst_move && mreq_reg.count == 13'h0001) || timed_out
                           || !mst_cancel_n);

    // state walk: request, wait grant, move phases, one cycle of termination
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mstate_reg <= pcilh_pkg::PCILH_M_IDLE;
        end else begin
            unique case (mstate_reg)
                pcilh_pkg::PCILH_M_IDLE: begin
                    if (req_any) begin
                        mstate_reg <= pcilh_pkg::PCILH_M_REQ;
                    end
                end
                pcilh_pkg::PCILH_M_REQ: begin
                    if (pci_gnt) begin
                        mstate_reg <= pcilh_pkg::PCILH_M_XFER;
                    end
                end
                pcilh_pkg::PCILH_M_XFER: begin
                    if (mst_stop) begin
                        mstate_reg <= pcilh_pkg::PCILH_M_TERM;
                    end
                end
                pcilh_pkg::PCILH_M_TERM: begin
                    mstate_reg <= pcilh_pkg::PCILH_M_IDLE;
                end
            endcase
        end
    end

    // request is latched at the grant, while the back-end still holds it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mreq_reg <= '{wide: 1'b0, read: 1'b0, count: pcilh_pkg::CNT_RST};
        end else if (mstate_reg == pcilh_pkg::PCILH_M_REQ && pci_gnt) begin
            mreq_reg.wide  <= !mst_request_wide_n;
            mreq_reg.read  <= mst_cmd_read;
            mreq_reg.count <= burst_len(mst_phase_count);
        end else if (mst_move) begin
            mreq_reg.count <= mreq_reg.count - 13'h0001;
        end
    end

    // handshake outputs, all registered
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pci_req_reg      <= 1'b0;
            granted_n_reg    <= 1'b1;
            mst_strobe_n_reg <= 1'b1;
            expired_n_reg    <= 1'b1;
        end else begin
            pci_req_reg      <= (mstate_reg == pcilh_pkg::PCILH_M_IDLE && req_any)
                                || (mstate_reg == pcilh_pkg::PCILH_M_REQ && !pci_gnt);
            granted_n_reg    <= !((mstate_reg == pcilh_pkg::PCILH_M_REQ && pci_gnt)
                                  || (mstate_reg == pcilh_pkg::PCILH_M_XFER && !mst_stop));
            mst_strobe_n_reg <= !mst_move;
            // held low through termination so the back-end sees it
            expired_n_reg    <= !(mstate_reg == pcilh_pkg::PCILH_M_XFER && timed_out);
        end
    end

    // phase state mirrors the sequencer for the back-end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= pcilh_pkg::PH_IDLE;
        end else begin
            unique case (mstate_reg)
                pcilh_pkg::PCILH_M_IDLE: phase_reg <= req_any ? pcilh_pkg::PH_ADDR
                                                              : pcilh_pkg::PH_IDLE;
                pcilh_pkg::PCILH_M_REQ:  phase_reg <= pci_gnt ? pcilh_pkg::PH_XFER
                                                              : pcilh_pkg::PH_ADDR;
                pcilh_pkg::PCILH_M_XFER: phase_reg <= mst_stop ? pcilh_pkg::PH_TERM
                                                               : pcilh_pkg::PH_XFER;
                pcilh_pkg::PCILH_M_TERM: phase_reg <= pcilh_pkg::PH_IDLE;
            endcase
        end
    end

    // shared output bus: target fifo words, else master read words
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            l_data_out_reg  <= pcilh_pkg::WORD_RST;
            mst_wr_word_reg <= pcilh_pkg::WORD_RST;
        end else begin
            if (tgt_pop) begin
                l_data_out_reg <= fifo_data;
            end else if (mst_move && mreq_reg.read) begin
                l_data_out_reg <= pci_mst_rd_data;
            end
            // write data is valid in the strobe cycle
            if (!mst_strobe_n_reg && !mreq_reg.read) begin
                mst_wr_word_reg <= l_ad_in;
            end
        end
    end

    assign tgt_xfer_strobe_n   = tgt_strobe_n_reg;
    assign tgt_access_strobe_n = access_n_reg;
    assign bar_hit             = bar_hit_reg;
    assign ext_cap_hit         = ext_cap_hit_reg;
    assign tgt_rd_word         = tgt_rd_word_reg;
    assign pci_req             = pci_req_reg;
    assign mst_granted_n       = granted_n_reg;
    assign mst_xfer_strobe_n   = mst_strobe_n_reg;
    assign mst_read_not_write  = mreq_reg.read;
    assign mst_expired_n       = expired_n_reg;
    assign mst_phase_state     = phase_reg;
    assign mst_wr_word         = mst_wr_word_reg;
    assign l_data_out          = l_data_out_reg;

    //==========================================================
    // assertions
    property p_tgt_strobe;
        @(posedge ref_clk) disable iff (!resetn)
        (tgt_pop || tgt_take) |=> !tgt_xfer_strobe_n;
    endproperty
    a_tgt_strobe: assert property (p_tgt_strobe) else $error("target strobe missing");

    property p_bus32;
        @(posedge ref_clk) disable iff (!resetn)
        !bus32_mode |=> tgt_xfer_strobe_n && mst_xfer_strobe_n;
    endproperty
    a_bus32: assert property (p_bus32) else $error("strobe on wide bus");

    property p_bar_hit;
        @(posedge ref_clk) disable iff (!resetn)
        pci_addr_valid |=> bar_hit == $past(pci_bar_match);
    endproperty
    a_bar_hit: assert property (p_bar_hit) else $error("bar hit mismatch");

    property p_cap_hit;
        @(posedge ref_clk) disable iff (!resetn)
        (pci_addr_valid && pci_cfg_access && pci_cfg_offset < pcilh_pkg::CFG_EXT_LO)
            |=> !ext_cap_hit;
    endproperty
    a_cap_hit: assert property (p_cap_hit) else $error("cap hit in header");

    property p_access;
        @(posedge ref_clk) disable iff (!resetn)
        (pci_special_cycle || (pci_addr_valid && (|pci_bar_match))) |=> !tgt_access_strobe_n;
    endproperty
    a_access: assert property (p_access) else $error("access strobe missing");

    property p_grant;
        @(posedge ref_clk) disable iff (!resetn)
        (mstate_reg == pcilh_pkg::PCILH_M_REQ && pci_gnt) |=> !mst_granted_n
            ##0 mst_phase_state == pcilh_pkg::PH_XFER;
    endproperty
    a_grant: assert property (p_grant) else $error("grant not shown");

    property p_zero_len;
        @(posedge ref_clk) disable iff (!resetn)
        (mstate_reg == pcilh_pkg::PCILH_M_REQ && pci_gnt && mst_phase_count == 12'h000)
            |=> mreq_reg.count == pcilh_pkg::BURST_MAX;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero count not 4096");

    property p_dir;
        @(posedge ref_clk) disable iff (!resetn)
        (mstate_reg == pcilh_pkg::PCILH_M_REQ && pci_gnt) |=> mst_read_not_write == $past(mst_cmd_read);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_expired;
        @(posedge ref_clk) disable iff (!resetn)
        (mstate_reg == pcilh_pkg::PCILH_M_XFER && timed_out) |=> !mst_expired_n
            ##1 mst_phase_state == pcilh_pkg::PH_IDLE;
    endproperty
    a_expired: assert property (p_expired) else $error("timeout not flagged");

    c_tgt_write: cover property (@(posedge ref_clk) disable iff (!resetn) tgt_pop);
    c_tgt_read:  cover property (@(posedge ref_clk) disable iff (!resetn) tgt_take);
    c_mst_done:  cover property (@(posedge ref_clk) disable iff (!resetn)
                                 mst_phase_state == pcilh_pkg::PH_TERM && mst_expired_n);
    c_full:      cover property (@(posedge ref_clk) disable iff (!resetn) !pci_wr_ready);
endmodule

// >>> hdl/pcilh_pkg.sv
// shared constants and carriers for the pci local-side handshake block
//==========================================================
package pcilh_pkg;
    // local data path
    localparam int DATA_W      = 32;
    localparam int FIFO_DEPTH  = 8;
    // configuration offsets owned by the back-end start here
    localparam logic [7:0]  CFG_EXT_LO   = 8'h40;
    // phase count of zero stands for the largest burst
    localparam logic [12:0] BURST_MAX    = 13'h1000;
    // master phase state codes seen by the back-end
    localparam logic [3:0]  PH_IDLE      = 4'h0;
    localparam logic [3:0]  PH_ADDR      = 4'h1;
    localparam logic [3:0]  PH_XFER      = 4'h2;
    localparam logic [3:0]  PH_TERM      = 4'h4;
    // reset values
    localparam logic [12:0] CNT_RST      = 13'h0000;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // master sequencer states
    typedef enum logic [1:0] {
        PCILH_M_IDLE = 2'b00,
        PCILH_M_REQ  = 2'b01,
        PCILH_M_XFER = 2'b10,
        PCILH_M_TERM = 2'b11
    } pcilh_mstate_t;

    // latched master request
    typedef struct packed {
        logic        wide;   // wide data request
        logic        read;   // read when high
        logic [12:0] count;  // data phases still to go
    } pcilh_mreq_t;
endpackage

// >>> tb/pcilh_backend_model.sv
// back-end model standing on the local side of the handshake block
`timescale 1ns/1ps

//==========================================================
// local back-end: ready control, stepping input words, output capture
module pcilh_backend_model (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        stall,               // hold both ready inputs off
    input  wire logic        restart,             // rewind word index, empty capture
    input  wire logic        tgt_xfer_strobe_n,
    input  wire logic        mst_xfer_strobe_n,
    input  wire logic [3:0]  mst_phase_state,
    input  wire logic [31:0] l_data_out,
    output logic             tgt_backend_ready_n,
    output logic             mst_backend_ready_n,
    output logic [31:0]      l_ad_in
);
    logic [23:0] idx_reg;                          // index of the word on offer
    logic [31:0] got_q [$];                        // words seen on the output bus

    // ready is a plain level so the bench can stall the data path at will
    assign tgt_backend_ready_n = stall;
    assign mst_backend_ready_n = stall;
    // each word is distinct so a lost or repeated word shows up
    assign l_ad_in = {8'hd0, idx_reg};

    // step the input word only after a strobe; the last phase strobe, which falls in
    // termination, is ignored, so the index does not move then
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idx_reg <= 24'h000000;
        end else if (restart) begin
            idx_reg <= 24'h000000;
            got_q.delete();
        end else if (!tgt_xfer_strobe_n ||
                     (!mst_xfer_strobe_n && mst_phase_state != pcilh_pkg::PH_TERM)) begin
            idx_reg <= idx_reg + 24'h000001;
            got_q.push_back(l_data_out);
        end
    end
endmodule

// >>> tb/pcilh_local_side_tb.sv
// self-checking bench for the pci local-side handshake block
`timescale 1ns/1ps

//==========================================================
// bench top: clock, reset, decode table, target and master tests
module pcilh_local_side_tb;
    logic        ref_clk, resetn, bus32_mode, pci_addr_valid, pci_exprom_match;
    logic        pci_cfg_access, pci_special_cycle, pci_wr_valid, pci_wr_ready, pci_rd_req;
    logic        pci_req, pci_gnt, pci_phase_ok, pci_latency_expired, tgt_access_strobe_n;
    logic        tgt_backend_ready_n, tgt_xfer_strobe_n, ext_cap_hit, mst_request_narrow_n;
    logic        mst_request_wide_n, mst_cmd_read, mst_backend_ready_n, mst_cancel_n;
    logic        mst_granted_n, mst_xfer_strobe_n, mst_read_not_write, mst_expired_n;
    logic        stall, restart, last_strobe_n;
    logic [5:0]  pci_bar_match, bar_hit;
    logic [7:0]  pci_cfg_offset;
    logic [11:0] mst_phase_count;
    logic [3:0]  mst_phase_state;
    logic [31:0] pci_wr_data, tgt_rd_word, pci_mst_rd_data, mst_wr_word, l_ad_in, l_data_out;
    int          err_total, n_compared, cyc, i, k;
    // decode rows: {bar match, rom match, cfg access, cfg offset, special}
    logic [16:0] din  [8] = '{17'h00800, 17'h10000, 17'h0027e, 17'h00280,
                              17'h003fe, 17'h00001, 17'h00400, 17'h00000};
    // expected {bar hit, capability hit, access strobe}
    logic [7:0]  dexp [8] = '{8'h04, 8'h80, 8'h01, 8'h02, 8'h02, 8'h00, 8'h00, 8'h01};

    pcilh_local_side dut (.ref_clk, .resetn, .bus32_mode, .pci_addr_valid, .pci_bar_match,
        .pci_exprom_match, .pci_cfg_access, .pci_cfg_offset, .pci_special_cycle,
        .pci_wr_valid, .pci_wr_ready, .pci_wr_data, .pci_rd_req, .tgt_rd_word, .pci_req,
        .pci_gnt, .pci_phase_ok, .pci_latency_expired, .pci_mst_rd_data, .mst_wr_word,
        .tgt_backend_ready_n, .tgt_xfer_strobe_n, .tgt_access_strobe_n, .bar_hit,
        .ext_cap_hit, .mst_request_narrow_n, .mst_request_wide_n, .mst_cmd_read,
        .mst_backend_ready_n, .mst_phase_count, .mst_cancel_n, .mst_granted_n,
        .mst_xfer_strobe_n, .mst_read_not_write, .mst_expired_n, .mst_phase_state,
        .l_ad_in, .l_data_out);
    pcilh_backend_model bfm (.ref_clk, .resetn, .stall, .restart, .tgt_xfer_strobe_n,
        .mst_xfer_strobe_n, .mst_phase_state, .l_data_out, .tgt_backend_ready_n,
        .mst_backend_ready_n, .l_ad_in);

    // inputs move 1 ns after the rising edge, never on it
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reset for 16 cycles, checking the idle state inside and after it
    task automatic do_reset();
        resetn = 1'b0;
        repeat (16) tick();
        chk({pci_req, tgt_xfer_strobe_n, tgt_access_strobe_n, mst_granted_n, mst_xfer_strobe_n,
             mst_expired_n, mst_phase_state, bar_hit, ext_cap_hit, pci_wr_ready}, 32'h1f001);
        resetn = 1'b1;
        tick();
        chk({mst_phase_state, pci_req, pci_wr_ready}, 32'h1);
    endtask
    // request, wait for the grant, release, then either run phases or stop early
    task automatic run_master(input logic wide, input logic rd, input logic [11:0] cnt,
                              input int exp_n, input int how);
        int n;
        n = 0;
        restart = 1'b1;
        tick();
        restart = 1'b0;
        stall = (how != 0);
        mst_cmd_read = rd;
        mst_phase_count = cnt;
        if (wide) mst_request_wide_n = 1'b0; else mst_request_narrow_n = 1'b0;
        for (i = 0; i < 20 && pci_req !== 1'b1; i++) tick();
        chk(mst_phase_state, pcilh_pkg::PH_ADDR);
        pci_gnt = 1'b1;
        for (i = 0; i < 20 && mst_granted_n !== 1'b0; i++) tick();
        chk(mst_granted_n, 32'h0);
        chk(mst_read_not_write, rd);
        mst_request_narrow_n = 1'b1;
        mst_request_wide_n = 1'b1;
        if (how == 1) mst_cancel_n = 1'b0;
        if (how == 2) {pci_latency_expired, pci_gnt} = 2'b10;
        for (i = 0; i < 5000 && mst_phase_state !== pcilh_pkg::PH_TERM; i++) begin
            if (mst_xfer_strobe_n === 1'b0) n++;
            if (rd && mst_xfer_strobe_n === 1'b0) chk(l_data_out, pci_mst_rd_data);
            tick();
            if (!rd && n > 0 && i > 0) chk(mst_wr_word, 32'hd000_0000 + 32'(n - 1));
        end
        // the last phase strobes in the cycle that already shows termination
        if (mst_xfer_strobe_n === 1'b0) n++;
        chk(n, exp_n);
        chk({mst_phase_state, mst_granted_n, mst_expired_n}, {pcilh_pkg::PH_TERM, 1'b1,
            1'(how != 2)});
        {pci_gnt, pci_latency_expired, mst_cancel_n, stall} = 4'b0010;
        tick();
        chk(mst_phase_state, pcilh_pkg::PH_IDLE);
        if (!rd && exp_n > 0) chk(mst_wr_word, 32'hd000_0000 + 32'(exp_n - 1));
        $display("master test wide %0d read %0d end %0d done", wide, rd, how);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard and a watch on target strobe spacing
    always @(posedge ref_clk) begin
        cyc++;
        if (last_strobe_n === 1'b0) chk(tgt_xfer_strobe_n, 32'h1);
        last_strobe_n = tgt_xfer_strobe_n;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {resetn, bus32_mode, pci_addr_valid, pci_exprom_match, pci_cfg_access} = 5'b01000;
        {pci_special_cycle, pci_wr_valid, pci_rd_req, pci_gnt, pci_phase_ok} = 5'b00001;
        {pci_latency_expired, mst_request_narrow_n, mst_request_wide_n} = 3'b011;
        {mst_cmd_read, mst_cancel_n, stall, restart, last_strobe_n} = 5'b01101;
        {pci_bar_match, pci_cfg_offset, mst_phase_count} = 26'h0;
        {pci_wr_data, pci_mst_rd_data} = {32'h0, 32'h5a5a_c3c3};
        {err_total, n_compared, cyc} = 96'h0;
        do_reset();
        for (k = 0; k < 8; k++) begin
            {pci_bar_match, pci_exprom_match, pci_cfg_access, pci_cfg_offset,
             pci_special_cycle} = din[k];
            pci_addr_valid = 1'b1;
            tick();
            chk({bar_hit, ext_cap_hit, tgt_access_strobe_n}, dexp[k]);
            {pci_addr_valid, pci_bar_match, pci_exprom_match, pci_cfg_access,
             pci_special_cycle} = 10'h0;
            tick();
        end
        $display("decode table done");
        // fill the buffer while the back-end stalls, then offer one word too many
        for (k = 0; k < 9; k++) begin
            {pci_wr_valid, pci_wr_data} = {1'b1, 32'hc000_0000 + 32'(k)};
            tick();
        end
        chk(pci_wr_ready, 32'h0);
        pci_wr_valid = 1'b0;
        stall = 1'b0;
        for (i = 0; i < 60 && bfm.got_q.size() < 8; i++) tick();
        tick();
        tick();
        chk(bfm.got_q.size(), 32'h8);
        for (k = 0; k < 8; k++) chk(bfm.got_q[k], 32'hc000_0000 + 32'(k));
        chk(pci_wr_ready, 32'h1);
        $display("buffer fill and drain done");
        // narrow bus mode off: word must wait until it is back on
        restart = 1'b1;
        bus32_mode = 1'b0;
        {pci_wr_valid, pci_wr_data} = {1'b1, 32'h1234_abcd};
        tick();
        {restart, pci_wr_valid} = 2'b00;
        repeat (10) tick();
        chk(bfm.got_q.size(), 32'h0);
        bus32_mode = 1'b1;
        for (i = 0; i < 10 && bfm.got_q.size() < 1; i++) tick();
        chk(bfm.got_q[0], 32'h1234_abcd);
        $display("bus width gate done");
        // two target reads: the second sees the word stepped after the first strobe
        restart = 1'b1;
        tick();
        restart = 1'b0;
        for (k = 0; k < 2; k++) begin
            pci_rd_req = 1'b1;
            for (i = 0; i < 20 && tgt_xfer_strobe_n !== 1'b0; i++) tick();
            pci_rd_req = 1'b0;
            repeat (2) tick();
            chk(tgt_rd_word, 32'hd000_0000 + 32'(k));
        end
        $display("target read done");
        run_master(1'b0, 1'b1, 12'h003, 3, 0);
        run_master(1'b1, 1'b0, 12'h001, 1, 0);
        run_master(1'b0, 1'b0, 12'h005, 5, 0);
        run_master(1'b0, 1'b1, 12'h000, 4096, 0);
        run_master(1'b0, 1'b1, 12'h010, 0, 1);
        run_master(1'b1, 1'b0, 12'h010, 0, 2);
        // reset in mid-run with one word waiting in the buffer
        stall = 1'b1;
        {pci_wr_valid, pci_wr_data} = {1'b1, 32'h0bad_0001};
        tick();
        pci_wr_valid = 1'b0;
        do_reset();
        $display("mid-run reset done");
        close_out();
    end
endmodule
